/* File: verilog/acbac_top.sv */
// The Avalon-MM register port was decided locally.
`include "acbac_defines.svh"
`default_nettype none
module acbac_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire acbac_pkg::acbac_req_t avs_req,
	output acbac_pkg::acbac_rsp_t avs_rsp,
	output acbac_pkg::acbac_adc_ctl_t adc_ctl,
	input wire logic adc_cal_done,
	input wire logic period_end,
	input wire logic [15:0] amp_value,
	output logic irq
);
	import acbac_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [1:0] sel_r;
	logic start_r;
	logic busy_r;
	logic mode_r;
	logic [11:0] stval_r;
	logic [31:0] thr_r;
	logic [2:0] cnt_sel_r;
	logic [1:0] stat_r;
	logic [1:0] mask_r;
	logic [31:0] rdata_r;
	logic ack_r;
	logic wreq_r;
	logic irq_r;
	logic go_r;
	acbac_cal_st_t cal_st_r;
	logic [15:0] wait_cnt_r;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic [31:0] rd_mux;
	logic wr_en;
	logic rd_en;
	logic cal_done_s1;
	logic cal_done_s2;
	logic period_s1;
	logic period_s2;
	logic period_s3;
	logic amp_err;
	logic cal_done_evt;
	logic [31:0] reg_sel;
	logic [31:0] reg_st;
	logic [31:0] stat_word;

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait state, ack pulse drops waitrequest.
	// A write lands only at the edge where waitrequest is low, so a
	// master that gives up early never leaves a half-done write behind.
	assign wr_en = avs_req.write && ack_r;
	assign rd_en = avs_req.read && !ack_r;
	assign wdat = avs_req.writedata;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{avs_req.byteenable[gi]}};
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			wreq_r <= 1'b1;
		end else if (ce) begin
			ack_r <= (avs_req.read || avs_req.write) && !ack_r;
			// Own flop so the bus sees no gate behind the register.
			wreq_r <= !((avs_req.read || avs_req.write) && !ack_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sel_r <= 2'h0;
			mode_r <= 1'b0;
			stval_r <= 12'h000;
			thr_r <= `ACBAC_THR_RST;
			cnt_sel_r <= `ACBAC_CNT_RST;
			mask_r <= 2'h0;
		end else if (ce && wr_en) begin
			case (avs_req.address)
				`ACBAC_OFS_CAL_SEL: begin
					sel_r <= (sel_r & ~wmask[11:10])
						| (wdat[11:10] & wmask[11:10]);
				end
				`ACBAC_OFS_CAL_ST: begin
					mode_r <= wmask[12] ? wdat[12] : mode_r;
					stval_r <= (stval_r & ~wmask[11:0])
						| (wdat[11:0] & wmask[11:0]);
				end
				`ACBAC_OFS_THR: begin
					thr_r <= (thr_r & ~wmask) | (wdat & wmask);
				end
				`ACBAC_OFS_AMP_CFG: begin
					cnt_sel_r <= wmask[2] ? wdat[2:0] : cnt_sel_r;
				end
				`ACBAC_OFS_IRQ_MASK: begin
					mask_r <= (mask_r & ~wmask[1:0]) | (wdat[1:0] & wmask[1:0]);
				end
				default: begin
					sel_r <= sel_r;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Calibration start: bit clears on the next edge.
	// start self-clears.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			start_r <= 1'b0;
		end else if (ce) begin
			start_r <= wr_en && avs_req.address == `ACBAC_OFS_CAL_ST
				&& wmask[`ACBAC_START_BIT] && wdat[`ACBAC_START_BIT];
		end
	end

	// Done from the analog side is asynchronous.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cal_done_s1 <= 1'b0;
			cal_done_s2 <= 1'b0;
			period_s1 <= 1'b0;
			period_s2 <= 1'b0;
			period_s3 <= 1'b0;
		end else if (ce) begin
			cal_done_s1 <= adc_cal_done;
			cal_done_s2 <= cal_done_s1;
			period_s1 <= period_end;
			period_s2 <= period_s1;
			period_s3 <= period_s2;
		end
	end

	// short launch delay, far below 2 ms. busy while running.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cal_st_r <= ACBAC_CAL_IDLE;
			wait_cnt_r <= 16'h0000;
			busy_r <= 1'b0;
			go_r <= 1'b0;
		end else if (ce) begin
			go_r <= 1'b0;
			case (cal_st_r)
				ACBAC_CAL_IDLE: begin
					if (start_r) begin
						cal_st_r <= ACBAC_CAL_WAIT;
						wait_cnt_r <= `ACBAC_CAL_LAUNCH_CYC;
						busy_r <= 1'b1;
					end
				end
				ACBAC_CAL_WAIT: begin
					if (wait_cnt_r == 16'h0000) begin
						cal_st_r <= ACBAC_CAL_RUN;
						go_r <= 1'b1;
					end else begin
						wait_cnt_r <= wait_cnt_r - 16'h0001;
					end
				end
				ACBAC_CAL_RUN: begin
					if (cal_done_s2 && !go_r) begin
						cal_st_r <= ACBAC_CAL_IDLE;
						busy_r <= 1'b0;
					end
				end
				default: begin
					cal_st_r <= ACBAC_CAL_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	assign cal_done_evt = cal_st_r == ACBAC_CAL_RUN && cal_done_s2 && !go_r;

	////////////////////////////////////////////////////////////////////////
	acbac_amp_check u_amp (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.period_end(period_s2 && !period_s3),
		.amp_value(amp_value),
		.upper(thr_r[31:16]),
		.lower(thr_r[15:0]),
		.cnt_sel(cnt_sel_r),
		.amp_err_pulse(amp_err)
	);

	////////////////////////////////////////////////////////////////////////
	// Sticky status: bit0 calibration done, bit1 amplitude error.
	// Set wins over the clear-on-read.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= 2'h0;
			irq_r <= 1'b0;
		end else if (ce) begin
			if (rd_en && avs_req.address == `ACBAC_OFS_IRQ_STAT) begin
				stat_r <= {amp_err, cal_done_evt};
			end else begin
				stat_r <= stat_r | {amp_err, cal_done_evt};
			end
			irq_r <= |(stat_r & mask_r);
		end
	end

	assign reg_sel = {20'h0_0000, sel_r, 10'h000};
	assign reg_st = {7'h00, busy_r, 7'h00, start_r, 3'h0, mode_r, stval_r};
	assign stat_word = {30'h0000_0000, stat_r};

	always_comb begin
		case (avs_req.address)
			`ACBAC_OFS_CAL_SEL: rd_mux = reg_sel;
			`ACBAC_OFS_CAL_ST: rd_mux = reg_st;
			`ACBAC_OFS_THR: rd_mux = thr_r;
			`ACBAC_OFS_IRQ_STAT: rd_mux = stat_word;
			`ACBAC_OFS_IRQ_MASK: rd_mux = {30'h0000_0000, mask_r};
			`ACBAC_OFS_AMP_CFG: rd_mux = {29'h0000_0000, cnt_sel_r};
			default: rd_mux = `ACBAC_ZERO32;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= `ACBAC_ZERO32;
		end else if (ce) begin
			rdata_r <= rd_en ? rd_mux : `ACBAC_ZERO32;
		end
	end

	assign avs_rsp.readdata = rdata_r;
	assign avs_rsp.waitrequest = wreq_r;
	assign adc_ctl.cal_setting = sel_r;
	assign adc_ctl.cal_go = go_r;
	assign adc_ctl.selftest_mode = mode_r;
	assign adc_ctl.selftest_value = stval_r;
	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////
	// A start request at the edge where its transfer completes.
	sequence s_start_write;
		ce && wr_en && avs_req.address == `ACBAC_OFS_CAL_ST
			&& avs_req.byteenable[2] && avs_req.writedata[16];
	endsequence

	// Launch pulse for one cycle while busy stands.
	sequence s_launch_busy;
		(go_r && busy_r) ##1 (!go_r && busy_r);
	endsequence

	// Completion seen, then idle with busy low.
	sequence s_cal_finish;
		cal_done_evt ##1 (cal_st_r == ACBAC_CAL_IDLE && !busy_r);
	endsequence

	AST_START_CLEARS: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && start_r |=> !start_r)
		else $error("Start bit did not self-clear.");

	AST_START_SETS: assert property (
		@(posedge mclk) disable iff (!rst_n)
		s_start_write |=> start_r)
		else $error("Start write not latched.");

	AST_CAL_LAUNCH: assert property (
		@(posedge mclk) disable iff (!rst_n)
		s_start_write and (cal_st_r == ACBAC_CAL_IDLE) |-> ##[1:40] go_r)
		else $error("Calibration did not launch in time.");

	AST_GO_PULSE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && go_r |-> s_launch_busy)
		else $error("Launch pulse malformed.");

	AST_BUSY_RUN: assert property (
		@(posedge mclk) disable iff (!rst_n)
		cal_st_r != ACBAC_CAL_IDLE |-> busy_r)
		else $error("Busy low during calibration.");

	AST_BUSY_DROP: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && cal_done_evt |-> s_cal_finish)
		else $error("Busy stays high after completion.");

	AST_BUSY_READ: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!avs_rsp.waitrequest && avs_req.read && $past(ce)
			&& avs_req.address == `ACBAC_OFS_CAL_ST
		|-> avs_rsp.readdata[24] == $past(busy_r))
		else $error("Busy flag misreported.");

	AST_SEL_OUT: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && wr_en && avs_req.address == `ACBAC_OFS_CAL_SEL
			&& avs_req.byteenable[1]
		|=> adc_ctl.cal_setting == $past(avs_req.writedata[11:10]))
		else $error("Setting output differs from register.");

	AST_RSVD_ZERO: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!avs_rsp.waitrequest && avs_req.read
			&& avs_req.address == `ACBAC_OFS_CAL_ST
		|-> avs_rsp.readdata[31:25] == 7'h00
			&& avs_rsp.readdata[23:17] == 7'h00
			&& avs_rsp.readdata[15:13] == 3'h0)
		else $error("Reserved bits not zero.");

	AST_WAIT_ONE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && !avs_rsp.waitrequest |=> avs_rsp.waitrequest)
		else $error("Waitrequest low for more than one cycle.");

	AST_THR_WRITE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && wr_en && avs_req.address == `ACBAC_OFS_THR
			&& avs_req.byteenable == 4'hF
		|=> thr_r == $past(avs_req.writedata))
		else $error("Word write to thresholds lost.");

	AST_THR_HALF: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && wr_en && avs_req.address == `ACBAC_OFS_THR
			&& avs_req.byteenable == 4'hC
		|=> thr_r[31:16] == $past(avs_req.writedata[31:16])
			&& thr_r[15:0] == $past(thr_r[15:0]))
		else $error("Halfword write to thresholds wrong.");

	AST_STVAL_WRITE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && wr_en && avs_req.address == `ACBAC_OFS_CAL_ST
			&& avs_req.byteenable[1:0] == 2'h3
		|=> stval_r == $past(avs_req.writedata[11:0]))
		else $error("Self-test value not stored.");

	AST_STAT_SET: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && amp_err |=> stat_r[1])
		else $error("Amplitude error not recorded in status.");
endmodule : acbac_top
`default_nettype wire

/* File: verilog/acbac_defines.svh */
`ifndef ACBAC_DEFINES_SVH
`define ACBAC_DEFINES_SVH

// Register byte offsets.
`define ACBAC_OFS_CAL_SEL 8'ha8
`define ACBAC_OFS_CAL_ST 8'hac
`define ACBAC_OFS_THR 8'hb0
`define ACBAC_OFS_IRQ_STAT 8'hc0
`define ACBAC_OFS_IRQ_MASK 8'hc4
`define ACBAC_OFS_AMP_CFG 8'hc8

// Field positions.
`define ACBAC_SEL_LSB 10
`define ACBAC_BUSY_BIT 24
`define ACBAC_START_BIT 16
`define ACBAC_STMODE_BIT 12
`define ACBAC_AMP_ERR_BIT 8

// Reset values.
`define ACBAC_THR_RST 32'h2000_0200
`define ACBAC_ZERO32 32'h0000_0000
`define ACBAC_CNT_RST 3'h0

// Timing: calibration must begin within this many microseconds.
`define ACBAC_CAL_START_US 2000
`define ACBAC_MCLK_MHZ 250
`define ACBAC_CAL_START_CYC (`ACBAC_CAL_START_US * `ACBAC_MCLK_MHZ)
// Launch delay used by this design, well inside the limit.
`define ACBAC_CAL_LAUNCH_CYC 16'h0004

`endif

/* File: verilog/acbac_pkg.sv */
`default_nettype none
package acbac_pkg;
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} acbac_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} acbac_rsp_t;

	typedef struct packed {
		logic [1:0] cal_setting;
		logic cal_go;
		logic selftest_mode;
		logic [11:0] selftest_value;
	} acbac_adc_ctl_t;

	typedef enum logic [1:0] {
		ACBAC_CAL_IDLE,
		ACBAC_CAL_WAIT,
		ACBAC_CAL_RUN
	} acbac_cal_st_t;
endpackage : acbac_pkg
`default_nettype wire

/* File: verilog/acbac_amp_check.sv */
`include "acbac_defines.svh"
`default_nettype none
module acbac_amp_check (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic period_end,
	input wire logic [15:0] amp_value,
	input wire logic [15:0] upper,
	input wire logic [15:0] lower,
	input wire logic [2:0] cnt_sel,
	output logic amp_err_pulse
);
	logic [6:0] err_cnt_r;
	logic [6:0] limit;
	logic out_of_range;

	always_comb begin
		case (cnt_sel)
			3'h1: limit = 7'd1;
			3'h2: limit = 7'd2;
			3'h4: limit = 7'd4;
			3'h5: limit = 7'd16;
			3'h7: limit = 7'd64;
			default: limit = 7'd8;
		endcase
	end

	assign out_of_range = (amp_value > upper) || (amp_value < lower);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			err_cnt_r <= 7'd0;
			amp_err_pulse <= 1'b0;
		end else if (ce) begin
			amp_err_pulse <= 1'b0;
			if (period_end) begin
				if (!out_of_range) begin
					err_cnt_r <= 7'd0;
				end else if (err_cnt_r >= limit) begin
					// Count is at or above the limit; report again.
					amp_err_pulse <= 1'b1;
				end else begin
					err_cnt_r <= err_cnt_r + 7'd1;
				end
			end
		end
	end

	AST_AMP_ERR_CAUSE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		amp_err_pulse |-> $past(period_end) && $past(out_of_range))
		else $error("Amplitude error without out-of-range period.");
	AST_IN_RANGE_CLEARS: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce && period_end && !out_of_range |=> err_cnt_r == 7'd0)
		else $error("Counter not cleared by in-range period.");
endmodule : acbac_amp_check
`default_nettype wire

/* File: tb/acbac_adc_model.sv */
`default_nettype none
module acbac_adc_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire acbac_pkg::acbac_adc_ctl_t adc_ctl,
	input wire logic [7:0] lat,
	output logic adc_cal_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] cnt_r;
	// Done rises lat cycles after the launch pulse and stays up six cycles.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 9'h000;
		end else if (adc_ctl.cal_go) begin
			cnt_r <= {1'b0, lat} + 9'h006;
		end else if (cnt_r != 9'h000) begin
			cnt_r <= cnt_r - 9'h001;
		end
	end
	assign adc_cal_done = (cnt_r != 9'h000) && (cnt_r <= 9'h006);
endmodule : acbac_adc_model
`default_nettype wire

/* File: tb/testbench.sv */
`include "acbac_defines.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import acbac_pkg::*;
	logic mclk, rst_n, ce, adc_cal_done, period_end, irq;
	logic [15:0] amp_value;
	logic [7:0] lat;
	acbac_req_t avs_req;
	acbac_rsp_t avs_rsp;
	acbac_adc_ctl_t adc_ctl;
	int n_mismatch, n_tests, seed, cyc, go_cyc, go_n, i, t0, n0;
	logic [31:0] rd, ac_exp;
	acbac_top i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.avs_req(avs_req), .avs_rsp(avs_rsp), .adc_ctl(adc_ctl),
		.adc_cal_done(adc_cal_done), .period_end(period_end),
		.amp_value(amp_value), .irq(irq));
	acbac_adc_model i_adc (.mclk(mclk), .rst_n(rst_n), .adc_ctl(adc_ctl),
		.lat(lat), .adc_cal_done(adc_cal_done));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (adc_ctl.cal_go === 1'b1) begin
			go_cyc <= cyc;
			go_n <= go_n + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Counts: %0d mismatches, %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s: expected %h, seen %h", what, e, g);
		end
	endtask : check
	// The request stands until waitrequest is sampled low at an edge.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		int k;
		@(posedge mclk);
		avs_req <= '{a, !wr, wr, be, d};
		for (k = 0; k < 50; k++) begin
			@(posedge mclk);
			if (avs_rsp.waitrequest === 1'b0) break;
		end
		if (k == 50) begin
			n_mismatch++;
			print_verdict();
		end
		rd = avs_rsp.readdata;
		avs_req <= '{8'h00, 1'b0, 1'b0, 4'h0, 32'h0000_0000};
	endtask : bus
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 4'hf, 32'h0000_0000);
		check($sformatf("reg %h", a), e, rd);
	endtask : rdchk
	// The amplitude is held steady around the period edge it belongs to.
	task automatic period(input logic [15:0] v);
		amp_value <= v;
		repeat (4) @(posedge mclk);
		period_end <= 1'b1;
		repeat (6) @(posedge mclk);
		period_end <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask : period
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h0000_efd7;
		n_mismatch = 0;
		n_tests = 0;
		cyc = 0;
		go_n = 0;
		go_cyc = 0;
		lat = 8'h02;
		rst_n = 1'b0;
		ce = 1'b1;
		period_end = 1'b0;
		amp_value = 16'h1000;
		avs_req = '0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		rdchk(`ACBAC_OFS_THR, `ACBAC_THR_RST);
		rdchk(`ACBAC_OFS_CAL_SEL, `ACBAC_ZERO32);
		rdchk(`ACBAC_OFS_CAL_ST, `ACBAC_ZERO32);
		rdchk(8'h04, `ACBAC_ZERO32);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, `ACBAC_OFS_CAL_SEL, 4'h2, 32'(k) << 10);
			rdchk(`ACBAC_OFS_CAL_SEL, 32'(k) << 10);
			check("cal_setting", 32'(k), 32'(adc_ctl.cal_setting));
		end
		for (int k = 0; k < 4; k++) begin
			ac_exp = 32'h0000_1000 | ($random(seed) & 32'h0000_0fff);
			bus(1'b1, `ACBAC_OFS_CAL_ST, 4'h3, ac_exp);
			rdchk(`ACBAC_OFS_CAL_ST, ac_exp);
			check("selftest", ac_exp,
				32'({adc_ctl.selftest_mode, adc_ctl.selftest_value}));
		end
		bus(1'b1, `ACBAC_OFS_THR, 4'h8, 32'h5a00_0000);
		rdchk(`ACBAC_OFS_THR, 32'h5a00_0200);
		bus(1'b1, `ACBAC_OFS_THR, 4'hc, 32'h3000_ffff);
		bus(1'b1, `ACBAC_OFS_THR, 4'h3, 32'hffff_0400);
		rdchk(`ACBAC_OFS_THR, 32'h3000_0400);
		for (int j = 0; j < 2; j++) begin
			lat <= j ? 8'h3c : 8'h02;
			bus(1'b1, `ACBAC_OFS_IRQ_MASK, 4'h1, 32'(j));
			bus(1'b1, `ACBAC_OFS_CAL_ST, 4'h4, 32'h0001_0000);
			t0 = cyc;
			n0 = go_n;
			rdchk(`ACBAC_OFS_CAL_ST, ac_exp | 32'h0100_0000);
			for (i = 0; i < 2000 && go_n == n0; i++) @(posedge mclk);
			check("launch", 32'h0000_0001, 32'((go_n != n0) &&
				(go_cyc - t0 <= `ACBAC_CAL_START_CYC)));
			for (i = 0; i < 100; i++) begin
				bus(1'b0, `ACBAC_OFS_CAL_ST, 4'hf, 32'h0000_0000);
				if (rd[24] === 1'b0) break;
			end
			check("busy end", ac_exp, rd);
			repeat (3) @(posedge mclk);
			check("irq", 32'(j), 32'(irq));
			rdchk(`ACBAC_OFS_IRQ_STAT, 32'h0000_0001);
			repeat (3) @(posedge mclk);
			check("irq clr", 32'h0000_0000, 32'(irq));
		end
		bus(1'b1, `ACBAC_OFS_AMP_CFG, 4'h1, 32'h0000_0001);
		bus(1'b1, `ACBAC_OFS_IRQ_MASK, 4'h1, 32'h0000_0003);
		period(16'h3000);
		period(16'h0400);
		for (int k = 0; k < 3; k++)
			period(16'(16'h0400 + ($unsigned($random(seed)) % 32'h0000_2c01)));
		rdchk(`ACBAC_OFS_IRQ_STAT, 32'h0000_0000);
		period(16'h3001);
		rdchk(`ACBAC_OFS_IRQ_STAT, 32'h0000_0000);
		period(16'hffff);
		check("irq amp", 32'h0000_0001, 32'(irq));
		rdchk(`ACBAC_OFS_IRQ_STAT, 32'h0000_0002);
		period(16'h03ff);
		rdchk(`ACBAC_OFS_IRQ_STAT, 32'h0000_0002);
		period(16'h1000);
		period(16'h03ff);
		rdchk(`ACBAC_OFS_IRQ_STAT, 32'h0000_0000);
		period(16'h0000);
		rdchk(`ACBAC_OFS_IRQ_STAT, 32'h0000_0002);
		// A period edge while the clock enable is low must go unseen.
		ce <= 1'b0;
		period(16'hffff);
		ce <= 1'b1;
		rdchk(`ACBAC_OFS_IRQ_STAT, 32'h0000_0000);
		check("irq frozen", 32'h0000_0000, 32'(irq));
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
